// >>> codec_regs_pkg.sv
package codec_regs_pkg;
  localparam logic [6:0] ADDR_FRONT_RATE = 7'h2C;
  localparam logic [6:0] ADDR_SURR_RATE = 7'h2E;
  localparam logic [6:0] ADDR_CSUB_RATE = 7'h30;
  localparam logic [6:0] ADDR_ADC_RATE = 7'h32;
  localparam logic [6:0] ADDR_CSUB_VOL = 7'h36;
  localparam logic [6:0] ADDR_SURR_VOL = 7'h38;
  localparam logic [6:0] ADDR_DOUT_CTRL = 7'h3A;
  localparam logic [6:0] ADDR_EXT_CTRL = 7'h2A;
  localparam logic [15:0] RATE_DEFAULT = 16'hBB80;
  localparam logic [15:0] RATE_MIN = 16'h1B58;
  localparam logic [15:0] VOL_DEFAULT = 16'h8888;
  localparam logic [15:0] DOUT_DEFAULT = 16'h2008;
  localparam logic [15:0] VOL_MASK = 16'h9F9F;
  localparam logic [15:0] DOUT_MASK = 16'hEFFF;
  localparam logic [15:0] EXT_MASK = 16'h0007;
  localparam int EXT_VRA_BIT = 0;
  localparam int EXT_DRA_BIT = 1;
  localparam int EXT_SPDIF_BIT = 2;
  localparam int VOL_HI_MUTE_BIT = 15;
  localparam int VOL_LO_MUTE_BIT = 7;
  localparam int DOUT_V_BIT = 15;
  localparam int DOUT_VFORCE_BIT = 14;
  localparam int DOUT_RATE_BIT = 13;
  localparam int DOUT_PRE_BIT = 3;
  localparam int CHAN_COUNT = 4;
  localparam int CHAN_FRONT = 0;
  localparam int CHAN_SURR = 1;
  localparam int CHAN_CSUB = 2;
  localparam int CHAN_ADC = 3;
endpackage

// >>> rate_slot.sv
`timescale 1ns/10ps
// one converter rate register; forced to 48 kHz while variable rate is off
module rate_slot (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_we,
  input wire logic [15:0] i_wdata,
  input wire logic i_var_rate,
  output logic [15:0] o_rate
);
  import codec_regs_pkg::*;
  typedef struct packed {
    logic [15:0] rate;
  } slot_s;
  slot_s st;
  slot_s next_st;
  always_comb begin
    next_st = st;
    if (!i_var_rate) begin
      next_st.rate = RATE_DEFAULT;
    end else if (i_we) begin
      next_st.rate = i_wdata;
    end
  end
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st <= '{rate: RATE_DEFAULT};
    end else begin
      st <= next_st;
    end
  end
  assign o_rate = st.rate;
endmodule

// >>> gain_decode.sv
`timescale 1ns/10ps
// turns a 5-bit code plus mute into an attenuation step count and a mute flag
module gain_decode (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [4:0] i_code,
  input wire logic i_mute,
  output logic [4:0] o_atten_steps,
  output logic o_muted
);
  import codec_regs_pkg::*;
  typedef struct packed {
    logic [4:0] steps;
    logic muted;
  } gd_s;
  gd_s st;
  gd_s next_st;
  always_comb begin
    next_st.steps = i_code;
    next_st.muted = i_mute;
  end
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st <= '{steps: VOL_DEFAULT[4:0], muted: VOL_DEFAULT[VOL_LO_MUTE_BIT]};
    end else begin
      st <= next_st;
    end
  end
  assign o_atten_steps = st.steps;
  assign o_muted = st.muted;
endmodule

// >>> codec_rate_volume_spdif_regs.sv
// The strobed register port was decided locally.
`timescale 1ns/10ps
// Functional notes
// - each converter rate is a 16-bit unsigned value in hertz
// - with variable rate off every rate reads and acts as 0xBB80
// - with variable rate on software writes set the converter rate
// - writing variable rate zero returns all rates to 48 kHz
// - double rate runs only front converters at twice the rate
// - double rate powers the surround converter down automatically
// - double rate powers the centre/subwoofer converter down automatically
// - gain fields are 5 bits, 32 steps of 1.5 dB
// - centre/subwoofer swap does not change gain or mute mapping
// - control fields go out as channel status; validity per subframe
// - emphasis bit clear means 50/15 us, set means none
// - variable rate enable also turns on slot request signalling
module codec_rate_volume_spdif_regs (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [6:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_err_detect,
  input wire logic i_center_sub_swap,
  output logic [15:0] o_rdata,
  output logic [15:0] o_front_rate,
  output logic [15:0] o_surround_rate,
  output logic [15:0] o_center_sub_rate,
  output logic [15:0] o_capture_rate,
  output logic o_double_rate,
  output logic o_surround_power_down,
  output logic o_center_sub_power_down,
  output logic o_slot_request_signalling,
  output logic [4:0] o_center_atten,
  output logic o_center_muted,
  output logic [4:0] o_subwoofer_atten,
  output logic o_subwoofer_muted,
  output logic [4:0] o_surround_left_atten,
  output logic o_surround_left_muted,
  output logic [4:0] o_surround_right_atten,
  output logic o_surround_right_muted,
  output logic o_center_sub_swap,
  output logic o_digital_out_enable,
  output logic [15:0] o_channel_status,
  output logic o_subframe_validity
);
  import codec_regs_pkg::*;

  function automatic logic hit(input logic [6:0] a, input logic [6:0] r);
    hit = (a == r);
  endfunction

  typedef struct packed {
    logic [15:0] ext_ctrl;
    logic [15:0] csub_vol;
    logic [15:0] surr_vol;
    logic [15:0] dout_ctrl;
    logic [15:0] rdata;
    logic dbl;
    logic surr_pd;
    logic csub_pd;
    logic slot_request_signalling;
    logic swap;
    logic dout_en;
    logic [15:0] cstat;
    logic validity;
    logic sw_q1;
    logic sw_q2;
    logic err_q1;
    logic err_q2;
  } top_s;
  top_s st;
  top_s next_st;

  logic [15:0] rate [CHAN_COUNT];
  logic [6:0] rate_addr [CHAN_COUNT];
  assign rate_addr[CHAN_FRONT] = ADDR_FRONT_RATE;
  assign rate_addr[CHAN_SURR] = ADDR_SURR_RATE;
  assign rate_addr[CHAN_CSUB] = ADDR_CSUB_RATE;
  assign rate_addr[CHAN_ADC] = ADDR_ADC_RATE;

  // rate slots see the new enable the same cycle a zero is written
  logic var_rate_now;
  always_comb begin
    var_rate_now = st.ext_ctrl[EXT_VRA_BIT];
    if (i_wr && hit(i_addr, ADDR_EXT_CTRL)) begin
      var_rate_now = i_wdata[EXT_VRA_BIT];
    end
  end

  genvar g;
  generate
    for (g = 0; g < CHAN_COUNT; g++) begin : g_rate
      rate_slot u_slot (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_we(i_wr && hit(i_addr, rate_addr[g])),
        .i_wdata(i_wdata),
        .i_var_rate(var_rate_now),
        .o_rate(rate[g])
      );
    end
  endgenerate

  // rate registers: the slot output is already registered, reading it
  // directly keeps each output one flop deep
  assign o_front_rate = rate[CHAN_FRONT];
  assign o_surround_rate = rate[CHAN_SURR];
  assign o_center_sub_rate = rate[CHAN_CSUB];
  assign o_capture_rate = rate[CHAN_ADC];

  always_comb begin
    next_st = st;
    next_st.sw_q1 = i_center_sub_swap;
    next_st.sw_q2 = st.sw_q1;
    next_st.err_q1 = i_err_detect;
    next_st.err_q2 = st.err_q1;
    if (i_wr) begin
      if (hit(i_addr, ADDR_EXT_CTRL)) begin
        next_st.ext_ctrl = i_wdata & EXT_MASK;
      end
      if (hit(i_addr, ADDR_CSUB_VOL)) begin
        next_st.csub_vol = i_wdata & VOL_MASK;
      end
      if (hit(i_addr, ADDR_SURR_VOL)) begin
        next_st.surr_vol = i_wdata & VOL_MASK;
      end
      if (hit(i_addr, ADDR_DOUT_CTRL)) begin
        // software is expected to write only with the transmitter off
        next_st.dout_ctrl = i_wdata & DOUT_MASK;
      end
    end
    next_st.rdata = 16'h0000;
    if (i_rd) begin
      for (int i = 0; i < CHAN_COUNT; i++) begin
        if (hit(i_addr, rate_addr[i])) begin
          next_st.rdata = rate[i];
        end
      end
      if (hit(i_addr, ADDR_EXT_CTRL)) begin
        next_st.rdata = st.ext_ctrl;
      end
      if (hit(i_addr, ADDR_CSUB_VOL)) begin
        next_st.rdata = st.csub_vol;
      end
      if (hit(i_addr, ADDR_SURR_VOL)) begin
        next_st.rdata = st.surr_vol;
      end
      if (hit(i_addr, ADDR_DOUT_CTRL)) begin
        next_st.rdata = st.dout_ctrl;
      end
    end
    next_st.dbl = st.ext_ctrl[EXT_DRA_BIT];
    next_st.surr_pd = st.ext_ctrl[EXT_DRA_BIT];
    next_st.csub_pd = st.ext_ctrl[EXT_DRA_BIT];
    next_st.slot_request_signalling = st.ext_ctrl[EXT_VRA_BIT];
    next_st.swap = st.sw_q2;
    next_st.dout_en = st.ext_ctrl[EXT_SPDIF_BIT];
    // validity bit travels per subframe, not in channel status
    next_st.cstat = st.dout_ctrl & ~((16'h0001 << DOUT_V_BIT) |
                                     (16'h0001 << DOUT_VFORCE_BIT));
    if (st.dout_ctrl[DOUT_VFORCE_BIT]) begin
      next_st.validity = st.dout_ctrl[DOUT_V_BIT];
    end else begin
      next_st.validity = st.err_q2;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st <= '{ext_ctrl: 16'h0000, csub_vol: VOL_DEFAULT, surr_vol: VOL_DEFAULT,
              dout_ctrl: DOUT_DEFAULT, rdata: 16'h0000, dbl: 1'b0, surr_pd: 1'b0,
              csub_pd: 1'b0, slot_request_signalling: 1'b0, swap: 1'b0, dout_en: 1'b0,
              cstat: DOUT_DEFAULT, validity: 1'b0, sw_q1: 1'b0, sw_q2: 1'b0,
              err_q1: 1'b0, err_q2: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // gain/mute fields keep the same channel whatever the swap says
  gain_decode u_center (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_code(st.csub_vol[4:0]), .i_mute(st.csub_vol[VOL_LO_MUTE_BIT]),
    .o_atten_steps(o_center_atten), .o_muted(o_center_muted)
  );
  gain_decode u_sub (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_code(st.csub_vol[12:8]), .i_mute(st.csub_vol[VOL_HI_MUTE_BIT]),
    .o_atten_steps(o_subwoofer_atten), .o_muted(o_subwoofer_muted)
  );
  gain_decode u_left (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_code(st.surr_vol[12:8]), .i_mute(st.surr_vol[VOL_HI_MUTE_BIT]),
    .o_atten_steps(o_surround_left_atten), .o_muted(o_surround_left_muted)
  );
  gain_decode u_right (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_code(st.surr_vol[4:0]), .i_mute(st.surr_vol[VOL_LO_MUTE_BIT]),
    .o_atten_steps(o_surround_right_atten), .o_muted(o_surround_right_muted)
  );

  assign o_rdata = st.rdata;
  assign o_double_rate = st.dbl;
  assign o_surround_power_down = st.surr_pd;
  assign o_center_sub_power_down = st.csub_pd;
  assign o_slot_request_signalling = st.slot_request_signalling;
  assign o_center_sub_swap = st.swap;
  assign o_digital_out_enable = st.dout_en;
  assign o_channel_status = st.cstat;
  assign o_subframe_validity = st.validity;
endmodule

// >>> codec_regs_asserts.sv
`timescale 1ns/10ps
module codec_regs_asserts
  import codec_regs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [6:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic [15:0] o_rdata,
  input wire logic [15:0] o_front_rate,
  input wire logic [15:0] o_surround_rate,
  input wire logic [15:0] o_center_sub_rate,
  input wire logic [15:0] o_capture_rate,
  input wire logic [15:0] o_channel_status,
  input wire logic o_double_rate,
  input wire logic o_surround_power_down,
  input wire logic o_center_sub_power_down,
  input wire logic o_slot_request_signalling,
  input wire logic o_center_muted,
  input wire logic o_subframe_validity,
  input wire logic [4:0] o_center_atten
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  // forced flag judged only once no later write can disturb it
  property p_valid;
    logic v;
    (i_wr && i_addr == ADDR_DOUT_CTRL && i_wdata[DOUT_VFORCE_BIT], v = i_wdata[DOUT_V_BIT])
      ##1 !i_wr [*2] |=> o_subframe_validity == v;
  endproperty
  AST_FIXED_RATE: assert property (!o_slot_request_signalling |->
    o_front_rate == RATE_DEFAULT && o_surround_rate == RATE_DEFAULT &&
    o_center_sub_rate == RATE_DEFAULT && o_capture_rate == RATE_DEFAULT)
    else $error("rate not 48k");
  AST_RATE_WRITE: assert property (i_wr && i_addr == ADDR_SURR_RATE && !$past(i_wr) &&
    o_slot_request_signalling |=> o_surround_rate == $past(i_wdata)) else $error("rate lost");
  AST_POWER_DOWN: assert property (i_wr && i_addr == ADDR_EXT_CTRL |-> ##2
    o_surround_power_down == $past(i_wdata[EXT_DRA_BIT], 2) &&
    o_center_sub_power_down == $past(i_wdata[EXT_DRA_BIT], 2)) else $error("power-down wrong");
  AST_EXT_BITS: assert property (i_wr && i_addr == ADDR_EXT_CTRL |-> ##2
    o_double_rate == $past(i_wdata[EXT_DRA_BIT], 2) &&
    o_slot_request_signalling == $past(i_wdata[EXT_VRA_BIT], 2)) else $error("ext bits wrong");
  AST_GAIN: assert property (i_wr && i_addr == ADDR_CSUB_VOL |-> ##2
    o_center_atten == $past(i_wdata[4:0], 2) &&
    o_center_muted == $past(i_wdata[VOL_LO_MUTE_BIT], 2)) else $error("gain wrong");
  AST_VALIDITY: assert property (p_valid) else $error("validity wrong");
  AST_STATUS: assert property (i_rd && i_addr == ADDR_DOUT_CTRL && !$past(i_wr) |=>
    o_channel_status == (o_rdata & 16'h3FFF)) else $error("status wrong");
  AST_READ_FIXED: assert property (i_rd && i_addr == ADDR_FRONT_RATE &&
    !o_slot_request_signalling |=> o_rdata == 16'hBB80) else $error("readback not 48k");
  cover property (o_double_rate);
  cover property (o_slot_request_signalling && o_front_rate != 16'hBB80);
  cover property (o_center_muted ##1 !o_center_muted);
endmodule
bind codec_rate_volume_spdif_regs codec_regs_asserts codec_regs_asserts_i (.*);

// >>> host_ctrl_model.sv
`timescale 1ns/10ps
// host side of the register link: one request per strobe, never both strobes
module host_ctrl_model (
  input wire logic i_clk,
  input wire logic [15:0] i_rdata,
  output logic [6:0] o_addr,
  output logic [15:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  initial begin
    o_addr = 7'h00;
    o_wdata = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // callers keep rates in 7k..48k and touch control only with the output off
  task automatic wr_reg(input logic [6:0] a, input logic [15:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [6:0] a, output logic [15:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    @(negedge i_clk);
    d = i_rdata;
  endtask
endmodule

// >>> codec_rate_volume_spdif_regs_test.sv
`timescale 1ns/10ps
module codec_rate_volume_spdif_regs_test;
  import codec_regs_pkg::*;
  logic i_clk, i_sys_rst, i_wr, i_rd, i_err_detect, i_center_sub_swap;
  logic [6:0] i_addr;
  logic [15:0] i_wdata, o_rdata, o_front_rate, o_surround_rate, o_center_sub_rate, r;
  logic [15:0] o_capture_rate, o_channel_status;
  logic o_double_rate, o_surround_power_down, o_center_sub_power_down;
  logic o_slot_request_signalling, o_center_muted, o_subwoofer_muted, o_surround_left_muted;
  logic o_surround_right_muted, o_center_sub_swap, o_digital_out_enable, o_subframe_validity;
  logic [4:0] o_center_atten, o_subwoofer_atten, o_surround_left_atten, o_surround_right_atten;
  logic [6:0] adr [7] = '{ADDR_FRONT_RATE, ADDR_SURR_RATE, ADDR_CSUB_RATE, ADDR_ADC_RATE,
    ADDR_CSUB_VOL, ADDR_SURR_VOL, ADDR_DOUT_CTRL};
  logic [15:0] rv [4] = '{16'h1B58, 16'h1B59, 16'hAC44, 16'hBB7F};
  int bad_count = 0;
  int checked = 0;
  codec_rate_volume_spdif_regs codec_rate_volume_spdif_regs_i (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_err_detect(i_err_detect),
    .i_center_sub_swap(i_center_sub_swap), .o_rdata(o_rdata),
    .o_front_rate(o_front_rate), .o_surround_rate(o_surround_rate),
    .o_center_sub_rate(o_center_sub_rate), .o_capture_rate(o_capture_rate),
    .o_double_rate(o_double_rate), .o_surround_power_down(o_surround_power_down),
    .o_center_sub_power_down(o_center_sub_power_down),
    .o_slot_request_signalling(o_slot_request_signalling),
    .o_center_atten(o_center_atten), .o_center_muted(o_center_muted),
    .o_subwoofer_atten(o_subwoofer_atten), .o_subwoofer_muted(o_subwoofer_muted),
    .o_surround_left_atten(o_surround_left_atten),
    .o_surround_left_muted(o_surround_left_muted),
    .o_surround_right_atten(o_surround_right_atten),
    .o_surround_right_muted(o_surround_right_muted),
    .o_center_sub_swap(o_center_sub_swap), .o_digital_out_enable(o_digital_out_enable),
    .o_channel_status(o_channel_status), .o_subframe_validity(o_subframe_validity)
  );
  host_ctrl_model host_ctrl_model_i (.i_clk(i_clk), .i_rdata(o_rdata), .o_addr(i_addr),
    .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [6:0] a, input logic [15:0] exp);
    host_ctrl_model_i.rd_reg(a, r);
    chk(r, exp);
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    host_ctrl_model_i.wr_reg(a, d);
  endtask
  task automatic stop_test;
    if (bad_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  initial begin
    repeat (3000) @(posedge i_clk);
    bad_count++;
    stop_test;
  end
  initial begin
    i_sys_rst = 1'b1;
    i_err_detect = 1'b0;
    i_center_sub_swap = 1'b0;
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    for (int k = 0; k < 7; k++) begin
      rchk(adr[k], k < 4 ? 16'hBB80 : k < 6 ? 16'h8888 : 16'h2008);
    end
    chk(o_channel_status, 16'h2008);
    chk({o_center_muted, o_center_atten}, 16'h28);
    wr(ADDR_FRONT_RATE, 16'h1B58);
    rchk(ADDR_FRONT_RATE, 16'hBB80);
    chk(o_front_rate, 16'hBB80);
    wr(ADDR_EXT_CTRL, 16'h0001);
    for (int k = 0; k < 4; k++) wr(adr[k], rv[k]);
    for (int k = 0; k < 4; k++) rchk(adr[k], rv[k]);
    chk(o_front_rate, rv[0]);
    chk(o_surround_rate, rv[1]);
    chk(o_center_sub_rate, rv[2]);
    chk(o_capture_rate, rv[3]);
    chk(o_slot_request_signalling, 16'h1);
    wr(ADDR_EXT_CTRL, 16'h0000);
    for (int k = 0; k < 4; k++) rchk(adr[k], 16'hBB80);
    chk(o_front_rate, 16'hBB80);
    chk(o_slot_request_signalling, 16'h0);
    wr(ADDR_EXT_CTRL, 16'h0002);
    rchk(ADDR_EXT_CTRL, 16'h0002);
    chk({o_double_rate, o_surround_power_down, o_center_sub_power_down}, 16'h7);
    wr(ADDR_EXT_CTRL, 16'h0000);
    wr(ADDR_CSUB_VOL, 16'h1F00);
    rchk(ADDR_CSUB_VOL, 16'h1F00);
    chk({o_subwoofer_muted, o_subwoofer_atten, o_center_muted, o_center_atten}, 16'h7C0);
    @(posedge i_clk);
    i_center_sub_swap <= 1'b1;
    repeat (5) @(posedge i_clk);
    chk(o_center_sub_swap, 16'h1);
    chk({o_subwoofer_muted, o_subwoofer_atten, o_center_muted, o_center_atten}, 16'h7C0);
    wr(ADDR_CSUB_VOL, 16'h6088);
    rchk(ADDR_CSUB_VOL, 16'h0088);
    chk({o_center_muted, o_center_atten}, 16'h28);
    wr(ADDR_SURR_VOL, 16'h8108);
    rchk(ADDR_SURR_VOL, 16'h8108);
    chk({o_surround_left_muted, o_surround_left_atten}, 16'h21);
    chk({o_surround_right_muted, o_surround_right_atten}, 16'h08);
    wr(ADDR_DOUT_CTRL, 16'h4008);
    rchk(ADDR_DOUT_CTRL, 16'h4008);
    chk(o_channel_status, 16'h0008);
    chk(o_subframe_validity, 16'h0);
    wr(ADDR_DOUT_CTRL, 16'hC008);
    rchk(ADDR_DOUT_CTRL, 16'hC008);
    chk(o_subframe_validity, 16'h1);
    @(posedge i_clk);
    i_err_detect <= 1'b1;
    wr(ADDR_DOUT_CTRL, 16'h0008);
    rchk(ADDR_DOUT_CTRL, 16'h0008);
    chk(o_subframe_validity, 16'h1);
    wr(ADDR_EXT_CTRL, 16'h0004);
    rchk(ADDR_EXT_CTRL, 16'h0004);
    chk(o_digital_out_enable, 16'h1);
    rchk(7'h00, 16'h0000);
    // a second reset in mid-run must bring back the surround volume, extended control, digital-out control and channel status defaults
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rchk(ADDR_SURR_VOL, 16'h8888);
    rchk(ADDR_EXT_CTRL, 16'h0000);
    rchk(ADDR_DOUT_CTRL, 16'h2008);
    chk(o_channel_status, 16'h2008);
    stop_test;
  end
endmodule
